// ===== src/tmr_io_pkg.sv
// constants for the dual timer and parallel port block
package tmr_io_pkg;
  localparam int DW = 8;
  localparam int TW = 16;
  localparam int AW = 4;
  // register select offsets
  localparam logic [3:0] OFF_PA_DATA = 4'h0;
  localparam logic [3:0] OFF_PB_DATA = 4'h1;
  localparam logic [3:0] OFF_PA_DIR = 4'h2;
  localparam logic [3:0] OFF_PB_DIR = 4'h3;
  localparam logic [3:0] OFF_TIMER_A_LOW_BYTE = 4'h4;
  localparam logic [3:0] OFF_TIMER_A_HIGH_BYTE = 4'h5;
  localparam logic [3:0] OFF_TIMER_B_LOW_BYTE = 4'h6;
  localparam logic [3:0] OFF_TIMER_B_HIGH_BYTE = 4'h7;
  localparam logic [3:0] OFF_CTRL_A = 4'hE;
  localparam logic [3:0] OFF_CTRL_B = 4'hF;
  // control register bit positions
  localparam int BIT_RUN = 0;
  localparam int BIT_OUT_EN = 1;
  localparam int BIT_TOGGLE = 2;
  localparam int BIT_ONE_SHOT = 3;
  localparam int BIT_LOAD = 4;
  localparam int BIT_SRC_LO = 5;
  localparam int BIT_SRC_HI = 6;
  // port b lines used by the timer outputs
  localparam int PB_LINE_SIX = 6;
  localparam int PB_LINE_SEVEN = 7;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] LATCH_RST = 16'hFFFF;
  // handshake strobe low time in cycles
  localparam logic [1:0] STROBE_CYCLES = 2'h2;
  // timer b count sources
  typedef enum logic [1:0] {
    SRC_CLK = 2'b00,
    SRC_PIN = 2'b01,
    SRC_UFL = 2'b10,
    SRC_UFL_LOW = 2'b11
  } src_b_t;
endpackage

// ===== src/dual_timer_io_ports.sv
// dual interval timer with two bidirectional parallel ports
// Overview of operation
// - each port: output register plus direction register
// - port data reads return sampled pin levels
// - port b access pulls strobe low two cycles
// - falling edge on handshake input sets flag
// - timer writes go to latch, reads counter
// - run bit starts or stops counting anytime
// - output enable drives line six or seven
// - underflow toggles output or pulses one cycle
// - toggle output set high on timer start
// - one-shot: underflow, reload, then stop
// - continuous: underflow, reload, keep counting
// - force load copies latch into counter
// - timer a counts clocks or count pin
// - timer b has four selectable count sources
// - load on underflow, force, stopped high write
// - running high write updates only the latch
// - select lines decode ports and timer bytes
// - separate control register for each timer
// - each underflow is distinct interrupt source
`timescale 1ns/1ps
module dual_timer_io_ports
  import tmr_io_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_cs,
  input wire logic i_rd_wr,
  input wire logic [AW-1:0] i_reg_sel,
  input wire logic [DW-1:0] i_wdata,
  output logic [DW-1:0] o_rdata,
  input wire logic [DW-1:0] i_port_a_pins,
  output logic [DW-1:0] o_port_a_pins,
  output logic [DW-1:0] o_port_a_oe,
  input wire logic [DW-1:0] i_port_b_pins,
  output logic [DW-1:0] o_port_b_pins,
  output logic [DW-1:0] o_port_b_oe,
  output logic o_handshake_strobe_out_n,
  input wire logic i_handshake_in_n,
  input wire logic i_count_pin,
  output logic o_handshake_flag,
  output logic o_timer_a_underflow,
  output logic o_timer_b_underflow
);

  logic [DW-1:0] pa_out_ff, pb_out_ff, pa_dir_ff, pb_dir_ff;
  logic [DW-1:0] pa_s1_ff, pa_s2_ff, pb_s1_ff, pb_s2_ff;
  logic hs_s1_ff, hs_s2_ff, hs_d_ff, cnt_s1_ff, cnt_s2_ff, cnt_d_ff;
  logic [1:0] strobe_ff;
  logic flag_ff;
  logic [DW-1:0] ctrl_ff [2];
  logic [TW-1:0] latch_ff [2];
  logic [TW-1:0] count_ff [2];
  logic [1:0] tout_ff, upulse_ff;
  logic [DW-1:0] rdata_ff;
  logic wr, rd, cnt_rise, hs_fall;
  logic [1:0] tick, ufl;

  // one access per enabled cycle with chip select
  assign wr = i_ce & i_cs & ~i_rd_wr;
  assign rd = i_ce & i_cs & i_rd_wr;

  function automatic logic is_reg(input logic [3:0] sel, input logic [3:0] off);
    return sel == off;
  endfunction

  // pins, count pin and handshake input pass two flops
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pa_s1_ff <= RST_BYTE;
      pa_s2_ff <= RST_BYTE;
      pb_s1_ff <= RST_BYTE;
      pb_s2_ff <= RST_BYTE;
      hs_s1_ff <= 1'b1;
      hs_s2_ff <= 1'b1;
      hs_d_ff <= 1'b1;
      cnt_s1_ff <= 1'b0;
      cnt_s2_ff <= 1'b0;
      cnt_d_ff <= 1'b0;
    end else if (i_ce) begin
      pa_s1_ff <= i_port_a_pins;
      pa_s2_ff <= pa_s1_ff;
      pb_s1_ff <= i_port_b_pins;
      pb_s2_ff <= pb_s1_ff;
      hs_s1_ff <= i_handshake_in_n;
      hs_s2_ff <= hs_s1_ff;
      hs_d_ff <= hs_s2_ff;
      cnt_s1_ff <= i_count_pin;
      cnt_s2_ff <= cnt_s1_ff;
      cnt_d_ff <= cnt_s2_ff;
    end
  end

  assign cnt_rise = cnt_s2_ff & ~cnt_d_ff;
  assign hs_fall = hs_d_ff & ~hs_s2_ff;

  // port data and direction registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pa_out_ff <= RST_BYTE;
      pb_out_ff <= RST_BYTE;
      pa_dir_ff <= RST_BYTE;
      pb_dir_ff <= RST_BYTE;
    end else if (wr) begin
      if (is_reg(i_reg_sel, OFF_PA_DATA)) begin
        pa_out_ff <= i_wdata;
      end else if (is_reg(i_reg_sel, OFF_PB_DATA)) begin
        pb_out_ff <= i_wdata;
      end else if (is_reg(i_reg_sel, OFF_PA_DIR)) begin
        pa_dir_ff <= i_wdata;
      end else if (is_reg(i_reg_sel, OFF_PB_DIR)) begin
        pb_dir_ff <= i_wdata;
      end
    end
  end

  // handshake strobe low for two cycles after port b access
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      strobe_ff <= 2'h0;
    end else if (i_ce) begin
      if ((wr | rd) && is_reg(i_reg_sel, OFF_PB_DATA)) begin
        strobe_ff <= STROBE_CYCLES;
      end else if (strobe_ff != 2'h0) begin
        strobe_ff <= strobe_ff - 2'h1;
      end
    end
  end
  assign o_handshake_strobe_out_n = (strobe_ff == 2'h0);

  // handshake flag: set by falling edge, cleared on a read of port b data
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag_ff <= 1'b0;
    end else if (i_ce) begin
      if (hs_fall) begin
        flag_ff <= 1'b1;
      end else if (rd && is_reg(i_reg_sel, OFF_PB_DATA)) begin
        flag_ff <= 1'b0;
      end
    end
  end
  assign o_handshake_flag = flag_ff;

  // count enables per timer
  always_comb begin
    tick[0] = ctrl_ff[0][BIT_RUN] &
              (ctrl_ff[0][BIT_SRC_LO] ? cnt_rise : 1'b1);
    ufl[0] = (count_ff[0] == RST_WORD) & tick[0];
    tick[1] = 1'b0;
    case (src_b_t'({ctrl_ff[1][BIT_SRC_HI], ctrl_ff[1][BIT_SRC_LO]}))
      SRC_CLK: tick[1] = 1'b1;
      SRC_PIN: tick[1] = cnt_rise;
      SRC_UFL: tick[1] = ufl[0];
      SRC_UFL_LOW: tick[1] = ufl[0] & ~cnt_s2_ff;
      default: tick[1] = 1'b0;
    endcase
    tick[1] = tick[1] & ctrl_ff[1][BIT_RUN];
    ufl[1] = (count_ff[1] == RST_WORD) & tick[1];
  end

  // per-timer latch, counter, control and output
  for (genvar t = 0; t < 2; t++) begin : g_tmr
    localparam logic [3:0] OFF_LO = t == 0 ? OFF_TIMER_A_LOW_BYTE : OFF_TIMER_B_LOW_BYTE;
    localparam logic [3:0] OFF_HI = t == 0 ? OFF_TIMER_A_HIGH_BYTE : OFF_TIMER_B_HIGH_BYTE;
    localparam logic [3:0] OFF_CR = t == 0 ? OFF_CTRL_A : OFF_CTRL_B;
    logic wr_hi, wr_cr, force_ld;
    assign wr_hi = wr & is_reg(i_reg_sel, OFF_HI);
    assign wr_cr = wr & is_reg(i_reg_sel, OFF_CR);
    assign force_ld = wr_cr & i_wdata[BIT_LOAD];

    // reload latch: every written timer byte goes here
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        latch_ff[t] <= LATCH_RST;
      end else if (wr && is_reg(i_reg_sel, OFF_LO)) begin
        latch_ff[t][DW-1:0] <= i_wdata;
      end else if (wr_hi) begin
        latch_ff[t][TW-1:DW] <= i_wdata;
      end
    end

    // control register; run bit cleared by one-shot underflow
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        ctrl_ff[t] <= RST_BYTE;
      end else if (wr_cr) begin
        ctrl_ff[t] <= i_wdata & ~(8'h01 << BIT_LOAD);
      end else if (i_ce && ufl[t] && ctrl_ff[t][BIT_ONE_SHOT]) begin
        ctrl_ff[t][BIT_RUN] <= 1'b0;
      end
    end

    // down counter with reload sources
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        count_ff[t] <= RST_WORD;
      end else if (i_ce) begin
        if (force_ld) begin
          count_ff[t] <= latch_ff[t];
        end else if (wr_hi && !ctrl_ff[t][BIT_RUN]) begin
          count_ff[t] <= {i_wdata, latch_ff[t][DW-1:0]};
        end else if (ufl[t]) begin
          count_ff[t] <= latch_ff[t];
        end else if (tick[t]) begin
          count_ff[t] <= count_ff[t] - 16'h0001;
        end
      end
    end

    // toggle level and one-cycle pulse
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        tout_ff[t] <= 1'b0;
        upulse_ff[t] <= 1'b0;
      end else if (i_ce) begin
        upulse_ff[t] <= ufl[t];
        if (wr_cr && i_wdata[BIT_RUN] && !ctrl_ff[t][BIT_RUN]) begin
          tout_ff[t] <= 1'b1;
        end else if (ufl[t]) begin
          tout_ff[t] <= ~tout_ff[t];
        end
      end
    end
  end

  assign o_timer_a_underflow = upulse_ff[0];
  assign o_timer_b_underflow = upulse_ff[1];

  // pins: timer outputs override lines six and seven
  always_comb begin
    o_port_a_pins = pa_out_ff;
    o_port_a_oe = pa_dir_ff;
    o_port_b_pins = pb_out_ff;
    o_port_b_oe = pb_dir_ff;
    if (ctrl_ff[0][BIT_OUT_EN]) begin
      o_port_b_oe[PB_LINE_SIX] = 1'b1;
      o_port_b_pins[PB_LINE_SIX] = ctrl_ff[0][BIT_TOGGLE] ? tout_ff[0] : upulse_ff[0];
    end
    if (ctrl_ff[1][BIT_OUT_EN]) begin
      o_port_b_oe[PB_LINE_SEVEN] = 1'b1;
      o_port_b_pins[PB_LINE_SEVEN] = ctrl_ff[1][BIT_TOGGLE] ? tout_ff[1] : upulse_ff[1];
    end
  end

  // registered read data
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_ff <= RST_BYTE;
    end else if (rd) begin
      if (is_reg(i_reg_sel, OFF_PA_DATA)) begin
        rdata_ff <= pa_s2_ff;
      end else if (is_reg(i_reg_sel, OFF_PB_DATA)) begin
        rdata_ff <= pb_s2_ff;
      end else if (is_reg(i_reg_sel, OFF_PA_DIR)) begin
        rdata_ff <= pa_dir_ff;
      end else if (is_reg(i_reg_sel, OFF_PB_DIR)) begin
        rdata_ff <= pb_dir_ff;
      end else if (is_reg(i_reg_sel, OFF_TIMER_A_LOW_BYTE)) begin
        rdata_ff <= count_ff[0][DW-1:0];
      end else if (is_reg(i_reg_sel, OFF_TIMER_A_HIGH_BYTE)) begin
        rdata_ff <= count_ff[0][TW-1:DW];
      end else if (is_reg(i_reg_sel, OFF_TIMER_B_LOW_BYTE)) begin
        rdata_ff <= count_ff[1][DW-1:0];
      end else if (is_reg(i_reg_sel, OFF_TIMER_B_HIGH_BYTE)) begin
        rdata_ff <= count_ff[1][TW-1:DW];
      end else if (is_reg(i_reg_sel, OFF_CTRL_A)) begin
        rdata_ff <= ctrl_ff[0];
      end else if (is_reg(i_reg_sel, OFF_CTRL_B)) begin
        rdata_ff <= ctrl_ff[1];
      end else begin
        rdata_ff <= RST_BYTE;
      end
    end
  end
  assign o_rdata = rdata_ff;

  // checks
  sequence s_pb_access;
    i_ce && i_cs && is_reg(i_reg_sel, OFF_PB_DATA);
  endsequence
  sequence s_strobe_low2;
    !o_handshake_strobe_out_n [*2];
  endsequence

  property p_strobe;
    @(posedge i_clk) disable iff (i_rst)
      s_pb_access |=> s_strobe_low2;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe not low two cycles");

  property p_flag;
    @(posedge i_clk) disable iff (i_rst) (i_ce && hs_fall) |=> o_handshake_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set by falling edge");

  property p_oneshot;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && ufl[0] && ctrl_ff[0][BIT_ONE_SHOT] && !wr) |=> !ctrl_ff[0][BIT_RUN];
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop");

  property p_reload;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && ufl[0] && !wr) |=> count_ff[0] == $past(latch_ff[0]);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on underflow");

  property p_hold;
    @(posedge i_clk) disable iff (i_rst)
      (!ctrl_ff[1][BIT_RUN] && !wr) |=> $stable(count_ff[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped timer changed");

  property p_pb6;
    @(posedge i_clk) disable iff (i_rst) ctrl_ff[0][BIT_OUT_EN] |-> o_port_b_oe[PB_LINE_SIX];
  endproperty
  a_pb6: assert property (p_pb6) else $error("line six not driven");

  property p_pulse;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && ufl[1]) |=> o_timer_b_underflow;
  endproperty
  a_pulse: assert property (p_pulse) else $error("missing underflow pulse");

  property p_force;
    @(posedge i_clk) disable iff (i_rst)
      (wr && is_reg(i_reg_sel, OFF_CTRL_A) && i_wdata[BIT_LOAD]) |=>
        count_ff[0] == $past(latch_ff[0]);
  endproperty
  a_force: assert property (p_force) else $error("force load failed");

  // starting timer b sets its toggle level high
  property p_toggle;
    @(posedge i_clk) disable iff (i_rst)
      (wr && is_reg(i_reg_sel, OFF_CTRL_B) && i_wdata[BIT_RUN] && !ctrl_ff[1][BIT_RUN]) |=>
        tout_ff[1];
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle level not set on start");

  // timer a pulse lasts one cycle unless a new underflow follows
  property p_pulse_a;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && o_timer_a_underflow && !ufl[0]) |=> !o_timer_a_underflow;
  endproperty
  a_pulse_a: assert property (p_pulse_a) else $error("underflow pulse too long");

endmodule // dual_timer_io_ports

// ===== testbench/bus_master_model.sv
// processor bus master model for the register interface
`timescale 1ns/1ps
module bus_master_model (
  input wire logic i_clk,
  output logic o_cs,
  output logic o_rd_wr,
  output logic [3:0] o_reg_sel,
  output logic [7:0] o_wdata
);
  // idle bus: deselected, read direction
  initial begin
    o_cs = 1'b0;
    o_rd_wr = 1'b1;
    o_reg_sel = 4'h0;
    o_wdata = 8'h00;
  end
  // one access: set up after an edge, held over the taking edge, then released
  task automatic acc(input logic rw, input logic [3:0] sel, input logic [7:0] d);
    @(posedge i_clk);
    o_cs <= 1'b1;
    o_rd_wr <= rw;
    o_reg_sel <= sel;
    o_wdata <= d;
    @(posedge i_clk);
    o_cs <= 1'b0;
    o_wdata <= ~d; // released data must not keep its last value
  endtask
  // word write: port a first so the port b strobe closes the word
  task automatic word_wr(input logic [15:0] w);
    acc(1'b0, 4'h0, w[7:0]);
    acc(1'b0, 4'h1, w[15:8]);
  endtask
endmodule // bus_master_model

// ===== testbench/dual_timer_io_ports_test.sv
// self-checking bench for the dual timer and port block
`timescale 1ns/1ps
module dual_timer_io_ports_test;
  import tmr_io_pkg::*;
  logic i_clk, i_rst, i_ce, i_cs, i_rd_wr, hs_n, cnt_pin, strobe_n, flag, uf_a, uf_b, rd_d;
  logic [3:0] sel;
  logic [7:0] wdata, rdata, pa_in, pb_in, pa_out, pa_oe, pb_out, pb_oe;
  logic [7:0] exp_q[$];
  logic [15:0] rnd;
  int err_count, checks_done, cycles, low_run, n;

  bus_master_model u_bus (.i_clk(i_clk), .o_cs(i_cs), .o_rd_wr(i_rd_wr), .o_reg_sel(sel),
    .o_wdata(wdata));

  dual_timer_io_ports dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_cs(i_cs),
    .i_rd_wr(i_rd_wr), .i_reg_sel(sel), .i_wdata(wdata), .o_rdata(rdata),
    .i_port_a_pins(pa_in), .o_port_a_pins(pa_out), .o_port_a_oe(pa_oe),
    .i_port_b_pins(pb_in), .o_port_b_pins(pb_out), .o_port_b_oe(pb_oe),
    .o_handshake_strobe_out_n(strobe_n), .i_handshake_in_n(hs_n), .i_count_pin(cnt_pin),
    .o_handshake_flag(flag), .o_timer_a_underflow(uf_a), .o_timer_b_underflow(uf_b));

  // clock at 25 MHz
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_bus.acc(1'b1, a, 8'h00);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_bus.acc(1'b0, a, d);
  endtask

  task automatic ticks(input int k);
    repeat (k) @(posedge i_clk);
  endtask

  // read data against the oldest note, strobe low length, hang limit
  always @(posedge i_clk) begin
    if (rd_d) check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    rd_d <= i_cs & i_rd_wr & i_ce;
    if (strobe_n === 1'b0) low_run++;
    else if (low_run != 0) begin
      check(16'(low_run), 16'h0002);
      low_run = 0;
    end
    cycles++;
    if (cycles > 4000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    hs_n = 1'b1;
    cnt_pin = 1'b0;
    rd_d = 1'b0;
    rnd = 16'h0025;
    pa_in = 8'h00;
    pb_in = 8'h00;
    err_count = 0;
    checks_done = 0;
    cycles = 0;
    low_run = 0;
    ticks(6);
    i_rst <= 1'b0;
    // reset state and an unmapped read
    rd(OFF_PA_DIR, 8'h00);
    rd(OFF_PB_DIR, 8'h00);
    rd(OFF_CTRL_A, 8'h00);
    rd(4'h8, 8'h00);
    check({pa_oe, pb_oe}, 16'h0000);
    // half of port a drives; reads show the pins
    rnd = lfsr(rnd);
    pa_in <= rnd[7:0];
    pb_in <= rnd[15:8];
    wr(OFF_PA_DIR, 8'hF0);
    u_bus.word_wr({~rnd[15:8], 8'h5A});
    #1 check({pa_oe, pa_out & pa_oe}, 16'hF050);
    rd(OFF_PA_DATA, rnd[7:0]);
    rd(OFF_PB_DATA, rnd[15:8]);
    // falling handshake edge sets the flag, rising does not clear it
    hs_n <= 1'b0;
    ticks(5);
    check({15'h0, flag}, 16'h0001);
    hs_n <= 1'b1;
    ticks(5);
    check({15'h0, flag}, 16'h0001);
    rd(OFF_PB_DATA, rnd[15:8]);
    ticks(2);
    check({15'h0, flag}, 16'h0000);
    // timer a one-shot, pulse out on line six
    wr(OFF_TIMER_A_LOW_BYTE, 8'h05);
    wr(OFF_TIMER_A_HIGH_BYTE, 8'h00);
    rd(OFF_TIMER_A_LOW_BYTE, 8'h05);
    wr(OFF_CTRL_A, 8'h0B);
    #1 check({15'h0, pb_oe[PB_LINE_SIX]}, 16'h0001);
    n = 0;
    while (uf_a !== 1'b1 && n < 50) begin
      ticks(1);
      n++;
    end
    check(16'(n), 16'h0007);
    check({15'h0, pb_out[PB_LINE_SIX]}, 16'h0001);
    ticks(1);
    check({15'h0, pb_out[PB_LINE_SIX]}, 16'h0000);
    rd(OFF_CTRL_A, 8'h0A);
    rd(OFF_TIMER_A_LOW_BYTE, 8'h05);
    // continuous mode repeats, period latch plus one
    wr(OFF_CTRL_A, 8'h01);
    n = 0;
    repeat (30) begin
      ticks(1);
      n += (uf_a === 1'b1);
      check({15'h0, uf_b}, 16'h0000);
    end
    check(16'(n), 16'h0004);
    // force load, then count three pin pulses
    wr(OFF_CTRL_A, 8'h31);
    repeat (3) begin
      cnt_pin <= 1'b1;
      ticks(4);
      cnt_pin <= 1'b0;
      ticks(4);
    end
    wr(OFF_CTRL_A, 8'h20);
    rd(OFF_TIMER_A_LOW_BYTE, 8'h02);
    // timer b: stopped high write loads, running high write only latches
    wr(OFF_TIMER_B_LOW_BYTE, 8'h34);
    wr(OFF_TIMER_B_HIGH_BYTE, 8'h12);
    rd(OFF_TIMER_B_HIGH_BYTE, 8'h12);
    wr(OFF_CTRL_B, 8'h07);
    ticks(2);
    check({14'h0, pb_oe[PB_LINE_SEVEN], pb_out[PB_LINE_SEVEN]}, 16'h0003);
    wr(OFF_TIMER_B_HIGH_BYTE, 8'h00);
    rd(OFF_TIMER_B_HIGH_BYTE, 8'h12);
    wr(OFF_CTRL_B, 8'h17);
    rd(OFF_TIMER_B_HIGH_BYTE, 8'h00);
    rd(OFF_CTRL_B, 8'h07);
    wr(OFF_CTRL_B, 8'h00);
    // timer b counts timer a underflows and toggles line seven
    wr(OFF_TIMER_B_LOW_BYTE, 8'h01);
    wr(OFF_TIMER_B_HIGH_BYTE, 8'h00);
    wr(OFF_CTRL_B, 8'h47);
    wr(OFF_CTRL_A, 8'h11);
    n = 0;
    repeat (24) begin
      ticks(1);
      n += (uf_b === 1'b1);
    end
    check(16'(n), 16'h0001);
    check({15'h0, pb_out[PB_LINE_SEVEN]}, 16'h0000);
    // a high count pin blocks the gated underflow source
    cnt_pin <= 1'b1;
    ticks(3);
    wr(OFF_CTRL_B, 8'h67);
    n = 0;
    repeat (24) begin
      ticks(1);
      n += (uf_b === 1'b1);
    end
    check(16'(n), 16'h0000);
    cnt_pin <= 1'b0;
    wr(OFF_CTRL_A, 8'h00);
    wr(OFF_CTRL_B, 8'h00);
    ticks(3);
    final_report();
  end
endmodule // dual_timer_io_ports_test
